// >>> rtl/vis_source.sv
// Source end: accept, wait, raise supply, announce ready
//
// Operation
// - Sink starts transition timer on Accept
// - Sink acknowledges Accept before evaluating it
// - Source waits transition interval after GoodCRC
// - Sink reaches standby power before interval ends
// - After interval, command supply to raise voltage
// - Supply ready within source-ready time, reported
// - Send PS_RDY only after supply ready
// - Sink acknowledges PS_RDY, permits new level
// - Sink resumes new level after evaluation
// - Sink load return respects transient limits (load ramp left to the device policy)
`timescale 1ns/10ps
module vis_source
    import vis_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Link
    vis_link_if.source link,
    // Policy side
    input  wire logic start,
    output logic      busy,
    output logic      done,
    output logic      ready_timeout,
    // Supply side
    output logic      supply_raise,
    input  wire logic supply_ready
);

    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_ACCEPT  = 6'h02,
        ST_WAIT    = 6'h04,
        ST_RAISE   = 6'h08,
        ST_PSRDY   = 6'h10,
        ST_ACK     = 6'h20
    } vis_src_state_type;

    // ==================================================================
    // Counter end points
    localparam logic [TIMER_WIDTH-1:0] WAIT_LAST  =
        TIMER_WIDTH'(SINK_TRANSITION_WAIT_CYC - 1);
    localparam logic [TIMER_WIDTH-1:0] READY_LAST =
        TIMER_WIDTH'(SOURCE_READY_TIME_CYC - 1);

    // ==================================================================
    // State
    vis_src_state_type        state_reg, state_next;
    logic [TIMER_WIDTH-1:0]   cnt_reg, cnt_next;
    logic                     valid_reg, valid_next;
    vis_msg_type              msg_reg, msg_next;
    logic                     raise_reg, raise_next;
    logic                     done_reg, done_next;
    logic                     tout_reg, tout_next;

    // ==================================================================
    // Events
    logic                     goodcrc_in;
    logic                     launch;
    logic                     acked;
    logic                     wait_over;
    logic                     ready_seen;
    logic                     ready_end;
    logic                     ps_acked;

    assign goodcrc_in = link.snk_msg_valid && (link.snk_msg == MSG_GOODCRC);
    // Start is taken in idle only; a start held while busy is refused
    assign launch     = (state_reg == ST_IDLE) && start;
    // The interval counts from the acknowledgement, not from the send
    assign acked      = (state_reg == ST_ACCEPT) && goodcrc_in;
    assign wait_over  = (state_reg == ST_WAIT) && (cnt_reg == WAIT_LAST);
    assign ready_seen = (state_reg == ST_RAISE) && supply_ready;
    assign ready_end  = (state_reg == ST_RAISE) && (cnt_reg == READY_LAST);
    assign ps_acked   = (state_reg == ST_ACK) && goodcrc_in;

    // ==================================================================
    // Sequence
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (launch) begin
                    state_next = ST_ACCEPT;
                end
            end
            ST_ACCEPT: begin
                if (acked) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (wait_over) begin
                    state_next = ST_RAISE;
                end
            end
            ST_RAISE: begin
                // PS_RDY is never sent before the supply reports ready
                if (ready_seen) begin
                    state_next = ST_PSRDY;
                end
            end
            ST_PSRDY: begin
                state_next = ST_ACK;
            end
            ST_ACK: begin
                if (ps_acked) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==================================================================
    // Interval and ready counter
    always_comb begin
        cnt_next = cnt_reg;
        if (acked || wait_over) begin
            cnt_next = '0;
        end else if (state_reg == ST_WAIT) begin
            cnt_next = cnt_reg + 1'h1;
        end else if ((state_reg == ST_RAISE) && !ready_end) begin
            cnt_next = cnt_reg + 1'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // ==================================================================
    // Link messages
    // One-cycle strobes; the code keeps its last value between them
    always_comb begin
        valid_next = 1'h0;
        msg_next   = msg_reg;
        if (launch) begin
            valid_next = 1'h1;
            msg_next   = MSG_ACCEPT;
        end else if (ready_seen) begin
            valid_next = 1'h1;
            msg_next   = MSG_PS_RDY;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            valid_reg <= 1'h0;
            msg_reg   <= MSG_NONE;
        end else begin
            valid_reg <= valid_next;
            msg_reg   <= msg_next;
        end
    end

    // ==================================================================
    // Supply command and status
    // Raise is held until reset, so the supply never sees a drop mid-run
    always_comb begin
        raise_next = raise_reg;
        done_next  = ps_acked;
        tout_next  = tout_reg;
        if (wait_over) begin
            raise_next = 1'h1;
        end
        // A late supply is only flagged; the sequence still waits for it
        if (launch) begin
            tout_next = 1'h0;
        end else if (ready_end && !supply_ready) begin
            tout_next = 1'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            raise_reg <= 1'h0;
            done_reg  <= 1'h0;
            tout_reg  <= 1'h0;
        end else begin
            raise_reg <= raise_next;
            done_reg  <= done_next;
            tout_reg  <= tout_next;
        end
    end

    // ==================================================================
    // Outputs
    assign link.src_msg_valid = valid_reg;
    assign link.src_msg       = msg_reg;
    assign supply_raise       = raise_reg;
    // Busy is a handshake output, decoded straight from the state register
    assign busy               = (state_reg != ST_IDLE);
    assign done               = done_reg;
    assign ready_timeout      = tout_reg;

endmodule

// >>> shared/vis_pkg.sv
// Package of message codes and timing counts for the voltage increase sequencer
package vis_pkg;

    // ==================================================================
    // Clock
    localparam int CLK_PERIOD_NS = 40;

    // ==================================================================
    // Message codes carried on the link
    typedef enum logic [2:0] {
        MSG_NONE     = 3'h0,
        MSG_ACCEPT   = 3'h1,
        MSG_GOODCRC  = 3'h2,
        MSG_PS_RDY   = 3'h3
    } vis_msg_type;

    // ==================================================================
    // Timing, in microseconds as the defaults, and derived cycle counts
    localparam int SINK_TRANSITION_WAIT_US = 20;
    localparam int SOURCE_READY_TIME_US    = 100;
    localparam int SINK_STANDBY_TIME_US    = 10;
    localparam int SUPPLY_TRANSITION_US    = 200;
    // Least time rounds up
    localparam int SINK_TRANSITION_WAIT_CYC =
        (SINK_TRANSITION_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest times round down
    localparam int SOURCE_READY_TIME_CYC =
        (SOURCE_READY_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int SINK_STANDBY_TIME_CYC =
        (SINK_STANDBY_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int SUPPLY_TRANSITION_CYC =
        (SUPPLY_TRANSITION_US * 1000) / CLK_PERIOD_NS;

    localparam int TIMER_WIDTH = 16;

endpackage

// >>> shared/vis_link_if.sv
// Interface joining the source end and the sink end of the sequencer
`timescale 1ns/10ps
interface vis_link_if;
    import vis_pkg::*;
    // Source to sink message strobe
    logic        src_msg_valid;
    vis_msg_type src_msg;
    // Sink to source message strobe
    logic        snk_msg_valid;
    vis_msg_type snk_msg;

    modport source (
        output src_msg_valid,
        output src_msg,
        input  snk_msg_valid,
        input  snk_msg
    );
    modport sink (
        input  src_msg_valid,
        input  src_msg,
        output snk_msg_valid,
        output snk_msg
    );
endinterface

// >>> rtl/vis_sink.sv
// Sink end: acknowledge, drop to standby, wait for PS_RDY
`timescale 1ns/10ps
module vis_sink
    import vis_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Link
    vis_link_if.sink  link,
    // Device policy side
    output logic      standby_cmd,
    output logic      new_level_ok,
    output logic      transition_fail,
    output logic      standby_late,
    // Supply side
    input  wire logic standby_reached
);

    typedef enum logic [3:0] {
        SK_IDLE    = 4'h1,
        SK_STANDBY = 4'h2,
        SK_PSWAIT  = 4'h4,
        SK_DONE    = 4'h8
    } vis_snk_state_type;

    vis_snk_state_type        state_reg, state_next;
    logic [TIMER_WIDTH-1:0]   tmr_reg, tmr_next;
    logic [TIMER_WIDTH-1:0]   sby_reg, sby_next;
    logic                     ack_reg, ack_next;
    logic                     sby_cmd_reg, sby_cmd_next;
    logic                     ok_reg, ok_next;
    logic                     fail_reg, fail_next;
    logic                     late_reg, late_next;
    logic                     accept_in;
    logic                     psrdy_in;

    assign accept_in = link.src_msg_valid && (link.src_msg == MSG_ACCEPT);
    assign psrdy_in  = link.src_msg_valid && (link.src_msg == MSG_PS_RDY);

    // ==================================================================
    // Sequence
    always_comb begin
        state_next   = state_reg;
        tmr_next     = tmr_reg;
        sby_next     = sby_reg;
        ack_next     = 1'b0;
        sby_cmd_next = sby_cmd_reg;
        ok_next      = ok_reg;
        fail_next    = fail_reg;
        late_next    = late_reg;
        case (state_reg)
            SK_IDLE: begin
                if (accept_in) begin
                    tmr_next   = '0;
                    sby_next   = '0;
                    ack_next   = 1'b1;
                    ok_next    = 1'b0;
                    fail_next  = 1'b0;
                    late_next  = 1'b0;
                    state_next = SK_STANDBY;
                end
            end
            SK_STANDBY: begin
                // Evaluation runs in the same cycle that the acknowledgement is on the link
                sby_cmd_next = 1'b1;
                tmr_next     = tmr_reg + 1'b1;
                state_next   = SK_PSWAIT;
            end
            SK_PSWAIT: begin
                // Standby must be reached well before the source's wait ends
                if (!standby_reached && !late_reg) begin
                    if (sby_reg ==
                        TIMER_WIDTH'(SINK_STANDBY_TIME_CYC - 1)) begin
                        late_next = 1'b1;
                    end else begin
                        sby_next = sby_reg + 1'b1;
                    end
                end
                if (psrdy_in) begin
                    ack_next     = 1'b1;
                    ok_next      = 1'b1;
                    sby_cmd_next = 1'b0;
                    state_next   = SK_DONE;
                end else if (tmr_reg ==
                             TIMER_WIDTH'(SUPPLY_TRANSITION_CYC - 1)) begin
                    fail_next    = 1'b1;
                    sby_cmd_next = 1'b0;
                    state_next   = SK_IDLE;
                end else begin
                    tmr_next = tmr_reg + 1'b1;
                end
            end
            SK_DONE: begin
                // Load ramp to the new level is left to the device policy
                state_next = SK_IDLE;
            end
            default: begin
                state_next = SK_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg   <= SK_IDLE;
            tmr_reg     <= '0;
            sby_reg     <= '0;
            ack_reg     <= 1'b0;
            sby_cmd_reg <= 1'b0;
            ok_reg      <= 1'b0;
            fail_reg    <= 1'b0;
            late_reg    <= 1'b0;
        end else begin
            state_reg   <= state_next;
            tmr_reg     <= tmr_next;
            sby_reg     <= sby_next;
            ack_reg     <= ack_next;
            sby_cmd_reg <= sby_cmd_next;
            ok_reg      <= ok_next;
            fail_reg    <= fail_next;
            late_reg    <= late_next;
        end
    end

    assign link.snk_msg_valid = ack_reg;
    assign link.snk_msg       = ack_reg ? MSG_GOODCRC : MSG_NONE;
    assign standby_cmd        = sby_cmd_reg;
    assign new_level_ok       = ok_reg;
    assign transition_fail    = fail_reg;
    assign standby_late       = late_reg;

endmodule

// >>> sim/vis_props.sv
// Checker of the link between the source and sink ends
`timescale 1ns/10ps
module vis_props
    import vis_pkg::*;
(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // Link
    input wire logic        src_msg_valid,
    input wire vis_msg_type src_msg,
    input wire logic        snk_msg_valid,
    input wire vis_msg_type snk_msg
);
    // ==========
    // Cycles since the Accept was acknowledged, saturating
    logic        acc_reg;
    logic        seen_reg;
    logic [12:0] gap_reg;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            acc_reg  <= 1'b0;
            seen_reg <= 1'b0;
            gap_reg  <= 13'h0;
        end else begin
            acc_reg <= src_msg_valid && src_msg == MSG_ACCEPT;
            if (acc_reg && snk_msg_valid) begin
                seen_reg <= 1'b1;
                gap_reg  <= 13'h0;
            end else if (gap_reg != 13'h1FFF) begin
                gap_reg <= gap_reg + 13'h1;
            end
        end
    end
    // ==========
    // Properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_accept;
        src_msg_valid && src_msg == MSG_ACCEPT;
    endsequence
    sequence s_ps_rdy;
        src_msg_valid && src_msg == MSG_PS_RDY;
    endsequence
    sequence s_ack;
        snk_msg_valid && snk_msg == MSG_GOODCRC;
    endsequence
    a_accept_acked: assert property (s_accept |=> s_ack)
        else $error("Accept not acknowledged next cycle");
    a_psrdy_acked: assert property (s_ps_rdy |=> s_ack)
        else $error("PS_RDY not acknowledged next cycle");
    a_ack_has_cause: assert property (
        snk_msg_valid |-> $past(src_msg_valid))
        else $error("Acknowledge without a message");
    a_ack_idle_code: assert property (
        !snk_msg_valid |-> snk_msg == MSG_NONE)
        else $error("Sink code not cleared when idle");
    a_src_one_cycle: assert property (
        src_msg_valid |=> !src_msg_valid)
        else $error("Source strobe longer than a cycle");
    a_src_legal_code: assert property (
        src_msg_valid |-> src_msg inside {MSG_ACCEPT, MSG_PS_RDY})
        else $error("Source sent an illegal code");
    a_wait_before_rdy: assert property (
        s_ps_rdy |-> seen_reg && gap_reg >= SINK_TRANSITION_WAIT_CYC)
        else $error("PS_RDY before the transition wait");
    a_quiet_after_ack: assert property (
        (acc_reg && snk_msg_valid) |=> !src_msg_valid [*8])
        else $error("Source message during transition wait");
    a_ack_single: assert property (s_ack |=> !snk_msg_valid)
        else $error("Acknowledge longer than a cycle");
endmodule

// >>> sim/vis_tb_top.sv
// Testbench driving both ends of the voltage increase sequencer
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
    $display("unexpected %s expected %h seen %h", nm, exp, got); \
    miscompares++; end end
module vis_tb_top;
    import vis_pkg::*;
    logic       ref_clk = 1'b0;
    logic       rst = 1'b1;
    logic       start = 1'b0;
    logic       supply_ready = 1'b0;
    logic       standby_reached = 1'b0;
    logic       busy, done, ready_timeout, supply_raise;
    logic       standby_cmd, new_level_ok, transition_fail;
    logic       standby_late;
    logic [5:0] probe;
    int         miscompares = 0;
    int         checks_done = 0;
    int         cyc = 0;
    int         acc_cnt = 0;
    int         n, t0;
    vis_link_if link ();
    vis_source vis_source_inst (.ref_clk(ref_clk), .rst(rst), .link(link),
        .start(start), .busy(busy), .done(done),
        .ready_timeout(ready_timeout), .supply_raise(supply_raise),
        .supply_ready(supply_ready));
    vis_sink vis_sink_inst (.ref_clk(ref_clk), .rst(rst), .link(link),
        .standby_cmd(standby_cmd), .new_level_ok(new_level_ok),
        .transition_fail(transition_fail), .standby_late(standby_late),
        .standby_reached(standby_reached));
    vis_props vis_props_inst (.ref_clk(ref_clk), .rst(rst),
        .src_msg_valid(link.src_msg_valid), .src_msg(link.src_msg),
        .snk_msg_valid(link.snk_msg_valid), .snk_msg(link.snk_msg));
    always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (link.src_msg_valid && link.src_msg == MSG_ACCEPT) acc_cnt++;
    end
    assign probe = {transition_fail, ready_timeout, supply_raise,
                    link.snk_msg_valid, link.src_msg_valid, done};
    // ==========
    // Tasks
    task automatic tick(input int k = 1);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task automatic end_sim();
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Bounded wait for one probe bit, cycles left in n
    task automatic wait_bit(input int b, input int lim);
        n = 0;
        while (probe[b] !== 1'b1) begin
            if (n >= lim) begin
                miscompares++;
                end_sim();
            end
            tick();
            n++;
        end
    endtask
    // ==========
    // Sequence
    initial begin
        tick(5);
        rst = 1'b0;
        start = 1'b1;
        tick();
        start = 1'b0;
        `CHK("accept", MSG_ACCEPT, link.src_msg)
        `CHK("busy", 1'b1, busy)
        tick();
        `CHK("ack", MSG_GOODCRC, link.snk_msg)
        tick();
        `CHK("standby", 1'b1, standby_cmd)
        // Start while busy must not launch a second Accept
        start = 1'b1;
        standby_reached = 1'b1;
        wait_bit(3, 600);
        start = 1'b0;
        `CHK("raise delay", SINK_TRANSITION_WAIT_CYC, n)
        tick(7);
        `CHK("no early ps_rdy", 1'b0, link.src_msg_valid)
        supply_ready = 1'b1;
        wait_bit(1, 8);
        `CHK("ps_rdy", MSG_PS_RDY, link.src_msg)
        tick();
        `CHK("ack ps_rdy", MSG_GOODCRC, link.snk_msg)
        `CHK("level ok", 1'b1, new_level_ok)
        `CHK("standby end", 1'b0, standby_cmd)
        tick();
        `CHK("done", 1'b1, done)
        `CHK("idle", 1'b0, busy)
        `CHK("no late flag", 1'b0, ready_timeout)
        `CHK("accepts", 1, acc_cnt)
        `CHK("no fail", 1'b0, transition_fail)
        `CHK("standby in time", 1'b0, standby_late)
        // Second reset after the first run ends, then a supply that never gets ready
        supply_ready = 1'b0;
        standby_reached = 1'b0;
        rst = 1'b1;
        tick(2);
        `CHK("raise cleared", 1'b0, supply_raise)
        `CHK("level cleared", 1'b0, new_level_ok)
        rst = 1'b0;
        start = 1'b1;
        tick();
        start = 1'b0;
        t0 = cyc;
        wait_bit(3, 600);
        wait_bit(4, 2600);
        `CHK("ready late", SOURCE_READY_TIME_CYC, n)
        wait_bit(5, 2600);
        // The sink takes the Accept one cycle after the source sends it
        `CHK("timer", SUPPLY_TRANSITION_CYC + 1, cyc - t0)
        `CHK("standby late", 1'b1, standby_late)
        `CHK("standby off", 1'b0, standby_cmd)
        `CHK("still busy", 1'b1, busy)
        end_sim();
    end
endmodule
